// ---- bench/kps_keys.sv ----
// Passive four by four key switch matrix model
`timescale 1ns/1ps
`default_nettype none
module kps_keys (
  input  wire logic [3:0]  row_drive_i,   // Row drive, high = row active
  input  wire logic [15:0] press_i,       // Closed keys, bit n is key n
  input  wire logic [3:0]  held_i,        // Columns tied high by the board
  output logic      [3:0]  column_line_o  // Column sense lines
);
  // ----------------------------------------------------------------
  // Column sensing
  // ----------------------------------------------------------------
  // Open columns sit on a pull-down, so nothing floats between rows
  // Key row times four plus column
  always_comb begin
    column_line_o = held_i;
    for (int k = 0; k < 16; k++) begin
      if (press_i[k] && row_drive_i[k / 4]) begin
        column_line_o[k % 4] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the matrix keypad scanner
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i     = 1'b0;     // Core clock, 50 ns period
  logic        rst_b_i   = 1'b0;     // Async reset, active low
  logic [3:0]  addr_i    = 4'h0;     // Register address
  logic [15:0] wr_data_i = 16'h0000; // Register write data
  logic        wr_i      = 1'b0;     // Write strobe
  logic        rd_i      = 1'b0;     // Read strobe
  logic [15:0] rd_data_o;            // Read data
  logic [3:0]  column_line_i;        // Columns from the matrix model
  logic [3:0]  row_drive_o;          // Rows to the matrix model
  logic        keypad_irq_n_o;       // Key interrupt, active low
  logic [15:0] press     = 16'h0000; // Keys held closed
  logic [3:0]  held      = 4'h0;     // Columns tied high
  logic [15:0] rdv;                  // Last read value
  logic [15:0] mask;                 // Random mask
  logic [15:0] keys;                 // Random press map
  int          err_count = 0;        // Mismatches
  int          n_checks  = 0;        // Comparisons
  int          hits;                 // Interrupt cycles seen
  int          seed;                 // Seed call result

  always #25 clk_i = ~clk_i;

  kps_scanner i_kps_scanner (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .column_line_i(column_line_i),
    .row_drive_o(row_drive_o), .keypad_irq_n_o(keypad_irq_n_o));
  kps_keys i_kps_keys (.row_drive_i(row_drive_o), .press_i(press),
    .held_i(held), .column_line_o(column_line_i));

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i      <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe edge
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rd_data_o;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Bounded wait; a lapse counts as a mismatch and ends the run
  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_i);
      #1;
      if (keypad_irq_n_o === 1'b0) break;
    end
    if (i == lim) begin
      chk({15'h0, keypad_irq_n_o}, 16'h0000);
      test_done();
    end
  endtask

  // Expected map: tied columns set all four keys, masked keys dropped
  function automatic logic [15:0] exp_map(input logic [15:0] p,
                                          input logic [3:0]  h,
                                          input logic [15:0] m);
    logic [15:0] e;
    e = p;
    for (int k = 0; k < 16; k++) begin
      if (h[k % 4]) e[k] = 1'b1;
    end
    return e & ~m;
  endfunction

  // One press: no early report, report held, read clears it
  task automatic run_key(input logic [15:0] p, input logic [3:0] h,
                         input logic [15:0] m, input logic [15:0] c);
    int f;
    int d;
    f = 800 * (int'(c[3:0]) + 1);
    d = int'(c[7:4]);
    bus_wr(kps_pkg::OFS_CTRL, c);
    bus_wr(kps_pkg::OFS_MASK, m);
    press <= p;
    held  <= h;
    cycles((d - 1) * f - 20);
    #1 chk({15'h0, keypad_irq_n_o}, 16'h0001);
    wait_irq((d + 2) * f);
    cycles(60);
    #1 chk({15'h0, keypad_irq_n_o}, 16'h0000);
    // Status: interrupt active, scanner holding the report
    bus_rd(kps_pkg::OFS_STAT, rdv);
    chk(rdv, 16'h0006);
    bus_rd(kps_pkg::OFS_DATA, rdv);
    chk(rdv, exp_map(p, h, m));
    chk({15'h0, keypad_irq_n_o}, 16'h0001);
    // Read data stands one cycle only, then falls to zero
    cycles(1);
    #1 chk(rd_data_o, 16'h0000);
    cycles(1);
    press <= 16'h0000;
    held  <= 4'h0;
    cycles(2 * f + 50);
    $display("test key %h done", p);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(4);
    cycles(8);
    rst_b_i <= 1'b1;
    bus_rd(kps_pkg::OFS_CTRL, rdv);
    chk(rdv, kps_pkg::CTRL_RST);
    bus_rd(kps_pkg::OFS_MASK, rdv);
    chk(rdv, kps_pkg::MASK_RST);
    bus_rd(4'h9, rdv);
    chk(rdv, 16'h0000);
    chk({15'h0, keypad_irq_n_o}, 16'h0001);
    $display("test reset done");
    run_key(16'h0001, 4'h0, 16'h0000, 16'h0020);
    run_key(16'h1000, 4'h0, 16'h0000, 16'h0020);
    run_key(16'h0000, 4'h1, 16'h0000, 16'h0020);
    run_key(16'h0000, 4'h8, 16'h0080, 16'h0021);
    for (int j = 0; j < 4; j++) begin
      mask    = 16'($urandom);
      keys    = 16'($urandom);
      mask[j] = 1'b0;
      keys[j] = 1'b1;
      run_key(keys, 4'h0, mask,
              {8'h00, 4'(2 + j % 2), 4'(j % 2)});
    end
    bus_wr(kps_pkg::OFS_CTRL, 16'h0020);
    bus_wr(kps_pkg::OFS_MASK, 16'hF0F0);
    press <= 16'hF0F0;
    hits = 0;
    for (int i = 0; i < 2600; i++) begin
      @(posedge clk_i);
      #1;
      if (keypad_irq_n_o !== 1'b1) hits++;
    end
    chk(16'(hits), 16'h0000);
    cycles(1);
    press <= 16'h0000;
    $display("test masked done");
    test_done();
  end
endmodule
`default_nettype wire

// ---- design/kps_pkg.sv ----
// Constants for the matrix keypad scanner
//
// Contract
// - Scan up to four rows by four columns
// - Control register sets scan rate, debounce
// - Masked keys never reported nor detected
// - Only a debounced scan result lands in data
// - Column held high reports whole column pressed
// - First column keys are 0, 4, 8, 12
// - Scan and debounce before interrupt goes low
// - All simultaneously pressed keys captured together
package kps_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 4;        // Register address width
  localparam int          DATA_W    = 16;       // Register data width
  localparam logic [3:0]  OFS_CTRL  = 4'h0;     // Scan rate and debounce
  localparam logic [3:0]  OFS_MASK  = 4'h1;     // Key exclusion mask
  localparam logic [3:0]  OFS_DATA  = 4'h2;     // Captured key map
  localparam logic [3:0]  OFS_STAT  = 4'h3;     // Scanner state view

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          RATE_LSB  = 0;        // Scan rate select low bit
  localparam int          RATE_W    = 4;        // Scan rate select width
  localparam int          DEB_LSB   = 4;        // Debounce frames low bit
  localparam int          DEB_W     = 4;        // Debounce frames width
  localparam logic [15:0] CTRL_RST  = 16'h0030; // Fastest rate, 3 frames
  localparam logic [15:0] MASK_RST  = 16'h0000; // No key excluded

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ      = 20;    // Core clock rate
  localparam int          STEP_UNIT_US = 10;    // Row dwell per rate step
  localparam int          STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Scanner states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,                                    // Waiting for a press
    ST_DEBOUNCE,                                // Confirming stable map
    ST_HELD                                     // Reported, await release
  } kps_state_t;

endpackage

// ---- design/kps_scanner.sv ----
// Matrix keypad scanner with register port and active-low interrupt
`timescale 1ns/1ps
`default_nettype none
module kps_scanner #(
  parameter int ROWS = 4,                       // Matrix rows
  parameter int COLS = 4                        // Matrix columns
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic [kps_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [kps_pkg::DATA_W-1:0]    wr_data_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [kps_pkg::DATA_W-1:0]    rd_data_o,
  input  wire logic [COLS-1:0]               column_line_i,
  output logic      [ROWS-1:0]               row_drive_o,
  output logic                               keypad_irq_n_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int KEYS = ROWS * COLS;            // Key positions

  logic [kps_pkg::DATA_W-1:0] ctrl_ff;          // Rate and debounce
  logic [kps_pkg::DATA_W-1:0] mask_ff;          // Excluded keys
  logic [KEYS-1:0]            key_data_ff;      // Reported key map
  logic [COLS-1:0]            col_meta_ff;      // Sync stage one
  logic [COLS-1:0]            col_sync_ff;      // Sync stage two
  logic [15:0]                step_cnt_ff;      // Row dwell timer
  logic [1:0]                 row_idx_ff;       // Active row
  logic [ROWS-1:0]            row_ff;           // One-hot row drive
  logic [KEYS-1:0]            scan_map_ff;      // Raw per-row samples
  logic                       frame_done_ff;    // Full frame captured
  logic [KEYS-1:0]            cand_ff;          // Debounce candidate
  logic [3:0]                 stable_ff;        // Matching frames seen
  logic                       irq_n_ff;         // Interrupt line
  logic [kps_pkg::DATA_W-1:0] rd_data_ff;       // Read return
  kps_pkg::kps_state_t        state_ff;         // Scanner state

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire       sel_ctrl = (addr_i == kps_pkg::OFS_CTRL);
  wire       sel_mask = (addr_i == kps_pkg::OFS_MASK);
  wire       sel_data = (addr_i == kps_pkg::OFS_DATA);
  wire       sel_stat = (addr_i == kps_pkg::OFS_STAT);
  wire       data_rd  = rd_i && sel_data;       // Clears the interrupt

  // Rate select stretches every row dwell by whole units
  wire [3:0] rate_sel = ctrl_ff[kps_pkg::RATE_LSB +: kps_pkg::RATE_W];
  wire [3:0] deb_sel  = ctrl_ff[kps_pkg::DEB_LSB +: kps_pkg::DEB_W];
  wire [15:0] step_lim = 16'(({12'h000, rate_sel} + 16'h0001)
                         * 16'(kps_pkg::STEP_UNIT_CYC)) - 16'h0001;
  // Zero would never settle; treat it as one frame
  // debounce frame count
  wire [3:0] deb_need = (deb_sel == 4'h0) ? 4'h1 : deb_sel;
  wire       step_end = (step_cnt_ff == step_lim);
  wire       last_row = (row_idx_ff == 2'(ROWS - 1));

  wire [KEYS-1:0] frame_map = scan_map_ff & ~mask_ff[KEYS-1:0];
  wire            any_key   = |frame_map;
  wire            same_map  = (frame_map == cand_ff);
  wire [3:0]      stable_up = stable_ff + 4'h1;
  wire latch = frame_done_ff && any_key
               && (((state_ff == kps_pkg::ST_DEBOUNCE) && same_map
                    && (stable_up >= deb_need))
                   || ((state_ff == kps_pkg::ST_IDLE)
                       && (deb_need == 4'h1)));

  // Read mux; unmapped addresses answer zero
  logic [kps_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    if (sel_ctrl) begin
      rd_mux = ctrl_ff;
    end else if (sel_mask) begin
      rd_mux = mask_ff;
    end else if (sel_data) begin
      rd_mux = kps_pkg::DATA_W'(key_data_ff);
    end else if (sel_stat) begin
      rd_mux = {13'h0000, ~irq_n_ff, 2'(state_ff)};
    end else begin
      rd_mux = '0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Control and mask writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= kps_pkg::CTRL_RST;
      mask_ff <= kps_pkg::MASK_RST;
    end else begin
      if (wr_i && sel_ctrl) ctrl_ff <= wr_data_i;
      if (wr_i && sel_mask) mask_ff <= wr_data_i;
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= rd_i ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // Column synchroniser
  // ----------------------------------------------------------------
  // Keys are asynchronous to the core clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col_meta_ff <= '0;
      col_sync_ff <= '0;
    end else begin
      col_meta_ff <= column_line_i;
      col_sync_ff <= col_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Row sweep
  // ----------------------------------------------------------------
  // one row at a time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_cnt_ff   <= '0;
      row_idx_ff    <= '0;
      row_ff        <= ROWS'(1);
      frame_done_ff <= 1'b0;
    end else begin
      frame_done_ff <= step_end && last_row;
      if (step_end || (step_cnt_ff > step_lim)) begin
        step_cnt_ff <= '0;
        row_idx_ff  <= last_row ? 2'b00 : row_idx_ff + 2'b01;
        row_ff      <= last_row ? ROWS'(1) : {row_ff[ROWS-2:0], 1'b0};
      end else begin
        step_cnt_ff <= step_cnt_ff + 16'h0001;
      end
    end
  end

  // Dwell is long, so sampled columns have settled by step end
  // One flop per key keeps every bit on a single constant driver
  // column high sets key bit
  // index is row times four plus column
  genvar gk;
  generate
    for (gk = 0; gk < KEYS; gk++) begin : g_key
      // Key belongs to row gk/COLS, column gk%COLS
      wire key_row = (row_idx_ff == 2'(gk / COLS));
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          scan_map_ff[gk] <= 1'b0;
        end else if (step_end && key_row) begin
          scan_map_ff[gk] <= col_sync_ff[gk % COLS];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Debounce and report
  // ----------------------------------------------------------------
  // Held state stops a long press from firing again
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff  <= kps_pkg::ST_IDLE;
      cand_ff   <= '0;
      stable_ff <= '0;
    end else if (frame_done_ff) begin
      case (state_ff)
        kps_pkg::ST_IDLE: begin
          cand_ff   <= frame_map;
          stable_ff <= 4'h1;
          if (latch) begin
            state_ff <= kps_pkg::ST_HELD;
          end else if (any_key) begin
            state_ff <= kps_pkg::ST_DEBOUNCE;
          end
        end
        kps_pkg::ST_DEBOUNCE: begin
          if (!any_key) begin
            state_ff <= kps_pkg::ST_IDLE;
          end else if (latch) begin
            state_ff <= kps_pkg::ST_HELD;
          end else if (same_map) begin
            stable_ff <= stable_up;
          end else begin
            cand_ff   <= frame_map;
            stable_ff <= 4'h1;
          end
        end
        kps_pkg::ST_HELD: begin
          if (!any_key) state_ff <= kps_pkg::ST_IDLE;
        end
        default: state_ff <= kps_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_data_ff <= '0;
    end else if (latch) begin
      key_data_ff <= frame_map;
    end
  end

  // New report beats a simultaneous read, so no press is lost
  // held until data read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_n_ff <= 1'b1;
    end else if (latch) begin
      irq_n_ff <= 1'b0;
    end else if (data_rd) begin
      irq_n_ff <= 1'b1;
    end
  end

  assign rd_data_o      = rd_data_ff;
  assign row_drive_o    = row_ff;
  assign keypad_irq_n_o = irq_n_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_row_onehot;
    @(posedge clk_i) disable iff (!rst_b_i)
      $onehot(row_ff) && (row_ff[row_idx_ff] == 1'b1);
  endproperty
  a_row_onehot: assert property (p_row_onehot)
    else $error("row drive not one-hot on active row");

  property p_dwell;
    @(posedge clk_i) disable iff (!rst_b_i)
      (step_cnt_ff == 16'h0000) && $stable(ctrl_ff) |->
        (row_idx_ff == $past(row_idx_ff))
        || $past(step_cnt_ff >= step_lim);
  endproperty
  a_dwell: assert property (p_dwell)
    else $error("row advanced before dwell elapsed");

  property p_masked;
    @(posedge clk_i) disable iff (!rst_b_i)
      latch |=> (key_data_ff & $past(mask_ff[KEYS-1:0])) == '0;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked key reported");

  property p_store;
    @(posedge clk_i) disable iff (!rst_b_i)
      latch |=> key_data_ff == $past(scan_map_ff & ~mask_ff[KEYS-1:0]);
  endproperty
  a_store: assert property (p_store)
    else $error("scan result not stored");

  property p_column;
    @(posedge clk_i) disable iff (!rst_b_i)
      step_end |=> scan_map_ff[{$past(row_idx_ff), 2'b00} +: 4]
                   == $past(col_sync_ff);
  endproperty
  a_column: assert property (p_column)
    else $error("column sample not placed in row nibble");

  property p_first_col;
    @(posedge clk_i) disable iff (!rst_b_i)
      step_end && (row_idx_ff == 2'd3) |=> scan_map_ff[12]
                                           == $past(col_sync_ff[0]);
  endproperty
  a_first_col: assert property (p_first_col)
    else $error("first column last row is not key twelve");

  property p_irq_cause;
    @(posedge clk_i) disable iff (!rst_b_i)
      $fell(irq_n_ff) |->
        $past(latch) && ($past(state_ff) != kps_pkg::ST_HELD);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without debounced scan");

  property p_multi;
    @(posedge clk_i) disable iff (!rst_b_i)
      latch && ($countones(frame_map) > 1) |=>
        $countones(key_data_ff) == $past($countones(frame_map));
  endproperty
  a_multi: assert property (p_multi)
    else $error("simultaneous keys not all captured");

  property p_irq_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      !irq_n_ff && !data_rd |=> !irq_n_ff;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt released without data read");

endmodule
`default_nettype wire
